//--- logic/dtc_pkg.sv
package dtc_pkg;

  // ==========================================================
  // register map, byte offsets in data memory space
  localparam logic [7:0] TIMER_A_COUNT_ADDR = 8'h0D;
  localparam logic [7:0] TIMER_A_CONTROL_ADDR = 8'h0E;
  localparam logic [7:0] TIMER_B_COUNT_HIGH_ADDR = 8'h0F;
  localparam logic [7:0] TIMER_B_COUNT_LOW_ADDR = 8'h10;
  localparam logic [7:0] TIMER_B_CONTROL_ADDR = 8'h11;

  // ==========================================================
  // control field positions
  localparam int EDGE_POLARITY_SEL_BIT = 3;
  localparam int COUNT_RUN_BIT = 4;
  localparam int MODE_SEL_LOW_BIT = 6;
  localparam int MODE_SEL_HIGH_BIT = 7;
  localparam logic [7:0] CONTROL_IMPL_MASK = 8'hD8;
  localparam logic [7:0] CONTROL_RESET = 8'h08;

  // ==========================================================
  // internal count rate: system clock divided by four
  localparam int PRESCALE_DIV = 4;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  typedef enum logic [1:0] {
    DTC_MODE_UNUSED = 2'b00,
    DTC_MODE_EVENT = 2'b01,
    DTC_MODE_TIMER = 2'b10,
    DTC_MODE_PULSE = 2'b11
  } dtc_mode_t;

  typedef enum logic [1:0] {
    DTC_PW_IDLE = 2'b00,
    DTC_PW_ARMED = 2'b01,
    DTC_PW_MEASURE = 2'b10,
    DTC_PW_DONE = 2'b11
  } dtc_pw_t;

  // cpu side access to the timer register block
  typedef struct packed {
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } dtc_bus_t;

  // per-counter overflow events and a shared wake towards the interrupt controller
  typedef struct packed {
    logic timer_a_overflow_flag;
    logic timer_b_overflow_flag;
    logic wake;
  } dtc_evt_t;

endpackage

//--- logic/dtc_timer.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - timer A is an 8-bit up-counter on pin or system clock over four
// - timer B is a 16-bit up-counter on pin or system clock over four
// - control bit 3 picks pin edge, 0 rising, 1 falling
// - control bit 4 runs counting when 1, stops when 0
// - bits 7:6 mode, 01 event, 10 timer, 11 pulse width, 00 unused
// - control bits 0 to 2 and 5 read as zero
// - timer A write goes to preload, read returns live count
// - timer B low write buffers, high write loads both preload bytes
// - timer B high read latches low count into buffer, low read returns buffer
// - event and timer modes count to all ones, reload and flag overflow
// - pulse mode counts from selected edge until level returns, clears run
// - pulse result kept, later edges ignored until run set again
// - pulse mode overflow reloads and flags as other modes
// - event and timer modes never clear run bit by themselves
// - overflow is a wake-up source out of halt
// - irq enable 0 blocks service only, flag still set
// - preload write while stopped loads counter too, else waits for overflow
// - count clock blocked during a counter read
// - reset leaves control at run off, falling edge selected

// ==========================================================
// one counter channel with its control register
module dtc_channel #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // qualifiers
  input wire logic tick4,
  input wire logic pin_sync,
  input wire logic pin_prev,
  input wire logic hold,
  // control register access
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_wdata,
  output logic [7:0] ctl_rdata,
  // preload access
  input wire logic pre_wr,
  input wire logic [WIDTH-1:0] pre_wdata,
  // state out
  output logic [WIDTH-1:0] count,
  output logic overflow
);
  import dtc_pkg::*;

  typedef struct packed {
    logic [7:0] ctl;
    logic [WIDTH-1:0] cnt;
    logic [WIDTH-1:0] pre;
    dtc_pw_t pw;
    logic ovf;
  } dtc_ch_state_t;

  dtc_ch_state_t s, next_s;
  dtc_mode_t mode;
  logic run, fall_sel, rise, fall, act_edge, ret_edge, inc;

  assign mode = dtc_mode_t'(s.ctl[MODE_SEL_HIGH_BIT:MODE_SEL_LOW_BIT]);
  assign run = s.ctl[COUNT_RUN_BIT];
  assign fall_sel = s.ctl[EDGE_POLARITY_SEL_BIT];
  assign rise = pin_sync & ~pin_prev;
  assign fall = ~pin_sync & pin_prev;
  assign act_edge = fall_sel ? fall : rise;
  assign ret_edge = fall_sel ? rise : fall;

  always_comb begin
    next_s = s;
    next_s.ovf = 1'b0;
    inc = 1'b0;
    case (mode)
      DTC_MODE_EVENT: inc = run & act_edge;
      DTC_MODE_TIMER: inc = run & tick4;
      DTC_MODE_PULSE: inc = run & (s.pw == DTC_PW_MEASURE) & tick4;
      default: inc = 1'b0;
    endcase
    if (hold) begin
      inc = 1'b0;
    end
    // pulse width sequencer
    if (mode != DTC_MODE_PULSE || !run) begin
      next_s.pw = run ? DTC_PW_ARMED : DTC_PW_IDLE;
    end else begin
      case (s.pw)
        DTC_PW_IDLE: next_s.pw = DTC_PW_ARMED;
        DTC_PW_ARMED: begin
          if (act_edge) begin
            next_s.pw = DTC_PW_MEASURE;
          end
        end
        DTC_PW_MEASURE: begin
          if (ret_edge) begin
            next_s.pw = DTC_PW_DONE;
            next_s.ctl[COUNT_RUN_BIT] = 1'b0;
          end
        end
        DTC_PW_DONE: next_s.pw = DTC_PW_DONE;
        default: next_s.pw = DTC_PW_IDLE;
      endcase
    end
    if (inc) begin
      if (&s.cnt) begin
        next_s.cnt = s.pre;
        next_s.ovf = 1'b1;
      end else begin
        next_s.cnt = s.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
    if (pre_wr) begin
      next_s.pre = pre_wdata;
      if (!run) begin
        next_s.cnt = pre_wdata;
      end
    end
    if (ctl_wr) begin
      next_s.ctl = ctl_wdata & CONTROL_IMPL_MASK;
      if (ctl_wdata[COUNT_RUN_BIT] && !run) begin
        next_s.pw = DTC_PW_IDLE;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.ctl <= CONTROL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign ctl_rdata = s.ctl;
  assign count = s.cnt;
  assign overflow = s.ovf;

  a_run_clears_pw: assert property (@(posedge mclk) disable iff (rst)
    (mode == DTC_MODE_PULSE && s.pw == DTC_PW_MEASURE && run && ret_edge && !ctl_wr)
    |=> !s.ctl[COUNT_RUN_BIT])
    else $error("pulse end did not clear run");
  a_run_kept: assert property (@(posedge mclk) disable iff (rst)
    (mode != DTC_MODE_PULSE && run && !ctl_wr) |=> run)
    else $error("run cleared itself");
  a_reload_value: assert property (@(posedge mclk) disable iff (rst)
    (inc && (&s.cnt) && !pre_wr) |=> (s.ovf && s.cnt == $past(s.pre)))
    else $error("overflow reload wrong");
  a_hold_freezes: assert property (@(posedge mclk) disable iff (rst)
    (hold && !pre_wr) |=> $stable(s.cnt))
    else $error("count moved during read");
  a_stop_preload: assert property (@(posedge mclk) disable iff (rst)
    (pre_wr && !run) |=> s.cnt == $past(pre_wdata))
    else $error("stopped preload not loaded");
  a_unused_zero: assert property (@(posedge mclk) disable iff (rst)
    (ctl_rdata & ~CONTROL_IMPL_MASK) == 8'h00)
    else $error("unused control bit set");
  a_done_ignores: assert property (@(posedge mclk) disable iff (rst)
    (s.pw == DTC_PW_DONE && !ctl_wr && !pre_wr && !hold) |=> $stable(s.cnt))
    else $error("count moved after measurement");
  a_stop_holds: assert property (@(posedge mclk) disable iff (rst)
    (!run && !pre_wr) |=> $stable(s.cnt))
    else $error("stopped counter moved");
  a_run_preload: assert property (@(posedge mclk) disable iff (rst)
    (pre_wr && run && !inc) |=> (s.pre == $past(pre_wdata) && $stable(s.cnt)))
    else $error("running preload touched count");
  a_timer_rate: assert property (@(posedge mclk) disable iff (rst)
    (mode == DTC_MODE_TIMER && !tick4 && !pre_wr) |=> $stable(s.cnt))
    else $error("timer counted off the divided rate");
  a_event_edge: assert property (@(posedge mclk) disable iff (rst)
    (mode == DTC_MODE_EVENT && !act_edge && !pre_wr) |=> $stable(s.cnt))
    else $error("event count without active edge");
  a_pulse_start: assert property (@(posedge mclk) disable iff (rst)
    (mode == DTC_MODE_PULSE && run && s.pw == DTC_PW_ARMED && act_edge && !ctl_wr)
    |=> s.pw == DTC_PW_MEASURE)
    else $error("pulse measurement did not start");
  c_overflow: cover property (@(posedge mclk) disable iff (rst) s.ovf);
  c_pulse_done: cover property (@(posedge mclk) disable iff (rst)
    s.pw == DTC_PW_MEASURE ##1 s.pw == DTC_PW_DONE);
  c_event_count: cover property (@(posedge mclk) disable iff (rst)
    mode == DTC_MODE_EVENT && inc);
endmodule

// ==========================================================
// top: two channels, prescaler, pin sync, register decode
module dtc_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // cpu data memory access
  input wire dtc_pkg::dtc_bus_t bus,
  output logic [7:0] rdata,
  // irq enables from the interrupt control register
  input wire logic timer_a_irq_enable,
  input wire logic timer_b_irq_enable,
  // overflow flag clears from the interrupt control register
  input wire logic timer_a_flag_clr,
  input wire logic timer_b_flag_clr,
  // timer input pins
  input wire logic timer_a_pin,
  input wire logic timer_b_pin,
  // events and flags
  output dtc_pkg::dtc_evt_t evt,
  output logic timer_a_overflow_flag,
  output logic timer_b_overflow_flag,
  output logic timer_a_irq,
  output logic timer_b_irq
);
  import dtc_pkg::*;

  typedef struct packed {
    logic [1:0] div;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic [7:0] low_buf;
    logic [7:0] rdata;
    logic fa;
    logic fb;
    dtc_evt_t evt;
  } dtc_top_state_t;

  dtc_top_state_t s, next_s;
  logic tick4;
  logic [7:0] ctl_a, ctl_b, cnt_a;
  logic [15:0] cnt_b;
  logic ovf_a, ovf_b;
  logic sel_a, sel_ac, sel_bh, sel_bl, sel_bc;

  assign tick4 = (s.div == PRESCALE_LAST);
  assign sel_a = bus.addr == TIMER_A_COUNT_ADDR;
  assign sel_ac = bus.addr == TIMER_A_CONTROL_ADDR;
  assign sel_bh = bus.addr == TIMER_B_COUNT_HIGH_ADDR;
  assign sel_bl = bus.addr == TIMER_B_COUNT_LOW_ADDR;
  assign sel_bc = bus.addr == TIMER_B_CONTROL_ADDR;

  dtc_channel #(.WIDTH(8)) u_chan_a (
    .mclk(mclk),
    .rst(rst),
    .tick4(tick4),
    .pin_sync(s.sync2[0]),
    .pin_prev(s.prev[0]),
    .hold(bus.rd & sel_a),
    .ctl_wr(bus.wr & sel_ac),
    .ctl_wdata(bus.wdata),
    .ctl_rdata(ctl_a),
    .pre_wr(bus.wr & sel_a),
    .pre_wdata(bus.wdata),
    .count(cnt_a),
    .overflow(ovf_a)
  );

  dtc_channel #(.WIDTH(16)) u_chan_b (
    .mclk(mclk),
    .rst(rst),
    .tick4(tick4),
    .pin_sync(s.sync2[1]),
    .pin_prev(s.prev[1]),
    .hold(bus.rd & sel_bh),
    .ctl_wr(bus.wr & sel_bc),
    .ctl_wdata(bus.wdata),
    .ctl_rdata(ctl_b),
    .pre_wr(bus.wr & sel_bh),
    .pre_wdata({bus.wdata, s.low_buf}),
    .count(cnt_b),
    .overflow(ovf_b)
  );

  always_comb begin
    next_s = s;
    next_s.div = s.div + 2'h1;
    next_s.sync1 = {timer_b_pin, timer_a_pin};
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    if (bus.wr && sel_bl) begin
      next_s.low_buf = bus.wdata;
    end
    if (bus.rd && sel_bh) begin
      next_s.low_buf = cnt_b[7:0];
    end
    next_s.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        TIMER_A_COUNT_ADDR: next_s.rdata = cnt_a;
        TIMER_A_CONTROL_ADDR: next_s.rdata = ctl_a;
        TIMER_B_COUNT_HIGH_ADDR: next_s.rdata = cnt_b[15:8];
        TIMER_B_COUNT_LOW_ADDR: next_s.rdata = s.low_buf;
        TIMER_B_CONTROL_ADDR: next_s.rdata = ctl_b;
        default: next_s.rdata = 8'h00;
      endcase
    end
    // set wins over clear
    next_s.fa = ovf_a | (s.fa & ~timer_a_flag_clr);
    next_s.fb = ovf_b | (s.fb & ~timer_b_flag_clr);
    next_s.evt.timer_a_overflow_flag = ovf_a;
    next_s.evt.timer_b_overflow_flag = ovf_b;
    next_s.evt.wake = ovf_a | ovf_b;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign evt = s.evt;
  assign timer_a_overflow_flag = s.fa;
  assign timer_b_overflow_flag = s.fb;
  assign timer_a_irq = s.fa & timer_a_irq_enable;
  assign timer_b_irq = s.fb & timer_b_irq_enable;

  a_flag_set_wins: assert property (@(posedge mclk) disable iff (rst)
    ovf_a |=> timer_a_overflow_flag)
    else $error("overflow flag lost");
  a_wake_pulse: assert property (@(posedge mclk) disable iff (rst)
    (ovf_a || ovf_b) |=> evt.wake)
    else $error("no wake on overflow");
  a_low_latch: assert property (@(posedge mclk) disable iff (rst)
    (bus.rd && sel_bh) |=> s.low_buf == $past(cnt_b[7:0]))
    else $error("low byte not latched");
  a_flag_clear: assert property (@(posedge mclk) disable iff (rst)
    (timer_a_flag_clr && !ovf_a) |=> !timer_a_overflow_flag)
    else $error("overflow flag not cleared");
  a_b_flag_set: assert property (@(posedge mclk) disable iff (rst)
    ovf_b |=> timer_b_overflow_flag)
    else $error("timer b flag lost");
  a_irq_gate: assert property (@(posedge mclk) disable iff (rst)
    !timer_a_irq_enable |-> !timer_a_irq)
    else $error("disabled irq raised");
  a_b_preload: assert property (@(posedge mclk) disable iff (rst)
    (bus.wr && sel_bh && !ctl_b[COUNT_RUN_BIT])
    |=> cnt_b == {$past(bus.wdata), $past(s.low_buf)})
    else $error("high write did not load both bytes");
  a_low_read: assert property (@(posedge mclk) disable iff (rst)
    (bus.rd && sel_bl) |=> rdata == $past(s.low_buf))
    else $error("low read not from buffer");
  c_b_overflow: cover property (@(posedge mclk) disable iff (rst) ovf_b);
endmodule
`default_nettype wire

//--- test/dtc_pulse_src.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// external event and pulse source on one timer pin
module dtc_pulse_src (
  // clock
  input wire logic mclk,
  // timer pin
  output logic pin
);
  initial pin = 1'b1;

  // n pulses away from the idle level, w cycles wide, w cycles apart
  task automatic pulses(input int n, input int w, input logic idle);
    pin = idle;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      repeat (w) @(posedge mclk);
      #1 pin = ~idle;
      repeat (w) @(posedge mclk);
      #1 pin = idle;
    end
    repeat (6) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

//--- test/dual_timer_event_counter_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module dual_timer_event_counter_tb_top;
  import dtc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  dtc_bus_t bus = '0;
  logic [7:0] rdata;
  logic a_en = 1'b0;
  logic b_en = 1'b0;
  logic a_clr = 1'b0;
  logic b_clr = 1'b0;
  logic pin_a;
  logic pin_b;
  dtc_evt_t evt;
  logic fa, fb, ia, ib;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int wakes = 0;
  int n_ovf_a = 0;
  int n_ovf_b = 0;
  int m_buf = 0;
  int m_pre_b = 0;
  int exp_q[$];
  int n;
  logic [7:0] v, lo, hi, w;

  always #10 mclk = ~mclk;

  dtc_timer u_dut (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
    .timer_a_irq_enable(a_en), .timer_b_irq_enable(b_en),
    .timer_a_flag_clr(a_clr), .timer_b_flag_clr(b_clr),
    .timer_a_pin(pin_a), .timer_b_pin(pin_b), .evt(evt),
    .timer_a_overflow_flag(fa), .timer_b_overflow_flag(fb),
    .timer_a_irq(ia), .timer_b_irq(ib));
  dtc_pulse_src u_src_a (.mclk(mclk), .pin(pin_a));
  dtc_pulse_src u_src_b (.mclk(mclk), .pin(pin_b));

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 bus = '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
    @(posedge mclk);
    #1 bus.wr = 1'b0;
    // reference model of the buffered byte path
    if (a == TIMER_B_COUNT_LOW_ADDR)
      m_buf = int'(d);
    if (a == TIMER_B_COUNT_HIGH_ADDR)
      m_pre_b = int'({d, m_buf[7:0]});
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1 bus = '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
    @(posedge mclk);
    #1 bus.rd = 1'b0;
    d = rdata;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (evt.wake === 1'b1)
      wakes <= wakes + 1;
    if (evt.timer_a_overflow_flag === 1'b1)
      n_ovf_a <= n_ovf_a + 1;
    if (evt.timer_b_overflow_flag === 1'b1)
      n_ovf_b <= n_ovf_b + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(29));
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    rd(TIMER_A_CONTROL_ADDR, v);
    chk(v, CONTROL_RESET);
    rd(TIMER_B_CONTROL_ADDR, v);
    chk(v, CONTROL_RESET);
    rd(8'h20, v);
    chk(v, 8'h00);
    wr(TIMER_A_CONTROL_ADDR, 8'h27);
    rd(TIMER_A_CONTROL_ADDR, v);
    chk(v, 8'h27 & CONTROL_IMPL_MASK);
    // buffered byte access of timer b while stopped
    lo = 8'($urandom);
    hi = 8'($urandom);
    wr(TIMER_B_COUNT_LOW_ADDR, lo);
    wr(TIMER_B_COUNT_HIGH_ADDR, hi);
    rd(TIMER_B_COUNT_HIGH_ADDR, v);
    chk(v, m_pre_b[15:8]);
    rd(TIMER_B_COUNT_LOW_ADDR, v);
    chk(v, m_pre_b[7:0]);
    // timer a: preload while running waits for overflow
    wr(TIMER_A_COUNT_ADDR, 8'h80);
    wr(TIMER_A_CONTROL_ADDR, 8'h90);
    wr(TIMER_A_COUNT_ADDR, 8'hFE);
    rd(TIMER_A_COUNT_ADDR, v);
    chk(v[7:4], 4'h8);
    for (int k = 0; k < 3000 && fa !== 1'b1; k++)
      @(posedge mclk);
    #1;
    chk(fa, 1'b1);
    chk(ia, 1'b0);
    a_en = 1'b1;
    #1;
    chk(ia, 1'b1);
    chk(wakes > 0, 1'b1);
    chk(n_ovf_a > 0, 1'b1);
    rd(TIMER_A_COUNT_ADDR, v);
    chk(v[7:1], 7'h7F);
    rd(TIMER_A_CONTROL_ADDR, v);
    chk(v, 8'h90);
    wr(TIMER_A_CONTROL_ADDR, 8'h00);
    @(posedge mclk);
    #1 a_clr = 1'b1;
    @(posedge mclk);
    #1 a_clr = 1'b0;
    chk(fa, 1'b0);
    // event count on both edge polarities
    for (int e = 0; e < 2; e++) begin
      u_src_a.pulses(0, 1, e[0]);
      wr(TIMER_A_COUNT_ADDR, 8'h00);
      wr(TIMER_A_CONTROL_ADDR, 8'h50 | (8'(e) << EDGE_POLARITY_SEL_BIT));
      n = 3 + ($urandom % 5);
      exp_q.push_back(n);
      u_src_a.pulses(n, 3, e[0]);
      rd(TIMER_A_COUNT_ADDR, v);
      chk(v, 8'(exp_q.pop_front()));
      wr(TIMER_A_CONTROL_ADDR, 8'h00);
      // stopped counter ignores further pin events
      u_src_a.pulses(2, 3, e[0]);
      rd(TIMER_A_COUNT_ADDR, v);
      chk(v, 8'(n));
    end
    // single-shot pulse width on timer b
    u_src_b.pulses(0, 1, 1'b0);
    wr(TIMER_B_COUNT_LOW_ADDR, 8'h00);
    wr(TIMER_B_COUNT_HIGH_ADDR, 8'h00);
    wr(TIMER_B_CONTROL_ADDR, 8'hD0);
    u_src_b.pulses(1, 40, 1'b0);
    rd(TIMER_B_CONTROL_ADDR, v);
    chk(v, 8'hC0);
    rd(TIMER_B_COUNT_HIGH_ADDR, v);
    chk(v, 8'h00);
    rd(TIMER_B_COUNT_LOW_ADDR, w);
    n = 40 / PRESCALE_DIV;
    chk(w >= n - 1 && w <= n + 1, 1'b1);
    u_src_b.pulses(2, 40, 1'b0);
    rd(TIMER_B_COUNT_HIGH_ADDR, v);
    rd(TIMER_B_COUNT_LOW_ADDR, v);
    chk(v, w);
    // rearm: a fresh measurement adds to the kept count
    wr(TIMER_B_CONTROL_ADDR, 8'hD0);
    u_src_b.pulses(1, 20, 1'b0);
    rd(TIMER_B_CONTROL_ADDR, v);
    chk(v, 8'hC0);
    rd(TIMER_B_COUNT_HIGH_ADDR, v);
    rd(TIMER_B_COUNT_LOW_ADDR, v);
    n = 20 / PRESCALE_DIV;
    chk(v >= w + n - 1 && v <= w + n + 1, 1'b1);
    // timer b overflow, reload and irq gating
    wr(TIMER_B_COUNT_LOW_ADDR, 8'hFD);
    wr(TIMER_B_COUNT_HIGH_ADDR, 8'hFF);
    wr(TIMER_B_CONTROL_ADDR, 8'h90);
    for (int k = 0; k < 200 && fb !== 1'b1; k++)
      @(posedge mclk);
    #1;
    chk(fb, 1'b1);
    chk(ib, 1'b0);
    b_en = 1'b1;
    #1;
    chk(ib, 1'b1);
    chk(n_ovf_b > 0, 1'b1);
    wr(TIMER_B_CONTROL_ADDR, 8'h00);
    rd(TIMER_B_COUNT_HIGH_ADDR, v);
    chk(v, m_pre_b[15:8]);
    rd(TIMER_B_COUNT_LOW_ADDR, v);
    chk(v >= m_pre_b[7:0], 1'b1);
    @(posedge mclk);
    #1 b_clr = 1'b1;
    @(posedge mclk);
    #1 b_clr = 1'b0;
    chk(fb, 1'b0);
    chk(ib, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
